// >>> src/pqs_regs.sv
// Extended control and quick poll status registers with their datapath controls
// Notes on behaviour
// R1 - Setting the arm bit lets only the next management write alter guarded bits.
// R2 - Arm bit clears itself after the next management write.
// R3 - Management must re-arm before each further guarded write.
// R4 - Vendor reserved bits of the extended control register read zero.
// R5 - Management should write default values into reserved bits on every write.
// R6 - Hardware or power-on reset samples five address bits from LED pins.
// R7 - Software reset leaves the latched port address unchanged.
// R8 - Scrambler test bit forces descrambler to lose lock and resynchronise.
// R9 - At 100 Mb/s serial stream is NRZ when bit zero, NRZI when one.
// R10 - Invalid code bit with transmit error selects the alternate nibble map.
// R11 - Alternate map: low nibbles get leading zero; upper nibbles use fixed codes.
// R12 - Scrambler disable bypasses both scrambling and descrambling, idles unscrambled.
// R13 - Scrambling and descrambling act only at 100 Mb/s.
// R14 - Quick poll register is 16 bits read-only with defaults at reset.
// R15 - Event flags latch high on occurrence and hold until read.
// R16 - Premature end flag sets on two idles where data was expected.
// R17 - Halt flag sets on halt symbol, reads zero when none since read.
// R18 - Remote fault flag sets on detection and latches until read.
// R19 - Link bit latches low after any invalid link until read.
// R20 - Signal detect bit reads zero with signal, one without, unlatched.
// R21 - Latched event flag reads one if event since read, read clears it.
// R22 - Progress monitor updates only when next state code exceeds present one.
// R23 - Progress monitor clears on reset, negotiation disable or restart.
// R24 - Rate bit follows control bit in software mode, pin in hardware mode.
`timescale 1ns/10ps
module pqs_regs
	import pqs_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	input  wire logic                    soft_reset,
	input  wire logic [4:0]              led_addr_pins,
	input  wire logic                    mgmt_wr,
	input  wire logic                    mgmt_rd,
	input  wire logic [4:0]              mgmt_addr,
	input  wire logic [15:0]             mgmt_wdata,
	output logic      [15:0]             mgmt_rdata,
	output logic                         mgmt_rd_valid,
	output logic                         guard_write_en,
	output logic      [4:0]              phy_addr,
	input  wire logic                    hw_mode_pin,
	input  wire logic                    speed_sel_pin,
	input  wire logic                    duplex_sel_pin,
	input  wire logic                    speed_sel_ctrl,
	input  wire logic                    duplex_ctrl,
	input  wire logic [3:0]              tx_nibble,
	input  wire logic                    tx_er,
	input  wire logic [4:0]              tx_std_code,
	output logic      [4:0]              tx_code,
	input  wire logic                    tx_bit,
	output logic                         tx_serial,
	output logic                         scramble_en,
	output logic                         descramble_en,
	output logic                         desc_lock_loss,
	input  wire logic [PQS_EV_COUNT-1:0] status_events,
	input  wire logic                    link_valid,
	input  wire logic                    rx_signal_present,
	input  wire logic                    an_enable,
	input  wire logic                    an_restart,
	input  wire logic [2:0]              an_state,
	input  wire logic                    an_complete
);

	// Alternate transmit map used for invalid code testing
	function automatic logic [4:0] alt_code(input logic [3:0] nib);
		case (nib)
			4'h8:    alt_code = 5'h00;
			4'h9:    alt_code = 5'h0d;
			4'ha:    alt_code = 5'h0c;
			4'hb:    alt_code = 5'h11;
			4'hc:    alt_code = 5'h10;
			4'hd:    alt_code = 5'h19;
			4'he:    alt_code = 5'h18;
			4'hf:    alt_code = 5'h1f;
			default: alt_code = {1'b0, nib}; // R11
		endcase
	endfunction

	logic [4:0]              pins_s1_q, pins_s2_q, phy_addr_q, phy_addr_d;
	logic [4:0]              tx_code_q, tx_code_d;
	logic [2:0]              mode_s1_q, mode_s2_q, mon_q, mon_d;
	logic [1:0]              strap_cnt_q, strap_cnt_d;
	logic                    arm_q, arm_d, scr_test_q, scr_test_d, nrzi_q, nrzi_d;
	logic                    inv_code_q, inv_code_d, scr_dis_q, scr_dis_d, link_q, link_d;
	logic                    rd_valid_q, tx_serial_q, tx_serial_d;
	logic                    wr_ext, rd_qp, speed100, duplex_full;
	logic [PQS_EV_COUNT-1:0] ev_q, ev_d;
	logic [15:0]             rdata_q, rdata_d, ext_view, qp_view;

	// Pins cross into this clock through two stages before anything reads them
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			pins_s1_q <= 5'h00;
			pins_s2_q <= 5'h00;
			mode_s1_q <= 3'h0;
			mode_s2_q <= 3'h0;
		end
		else
		begin
			pins_s1_q <= led_addr_pins;
			pins_s2_q <= pins_s1_q;
			mode_s1_q <= {hw_mode_pin, speed_sel_pin, duplex_sel_pin};
			mode_s2_q <= mode_s1_q;
		end
	end

	// Selected technology; pins rule only in hardware mode
	assign speed100    = mode_s2_q[2] ? mode_s2_q[1] : speed_sel_ctrl; // R24
	assign duplex_full = mode_s2_q[2] ? mode_s2_q[0] : duplex_ctrl;
	assign wr_ext      = mgmt_wr && (mgmt_addr == PQS_ADDR_EXT_CTRL);
	assign rd_qp       = mgmt_rd && (mgmt_addr == PQS_ADDR_QUICK_POLL);

	// Address strap is taken once the synchroniser holds post-reset pin levels;
	// soft reset is not wired here so the address survives it
	always_comb
	begin
		strap_cnt_d = strap_cnt_q;
		phy_addr_d  = phy_addr_q;
		if (strap_cnt_q != 2'h0)
			strap_cnt_d = strap_cnt_q - 2'h1;
		if (strap_cnt_q == PQS_STRAP_TAKE)
			phy_addr_d = pins_s2_q; // R6 R7
	end

	// Control bits; a write that is not itself re-arming drops the arm bit
	always_comb
	begin
		arm_d      = arm_q;
		scr_test_d = scr_test_q;
		nrzi_d     = nrzi_q;
		inv_code_d = inv_code_q;
		scr_dis_d  = scr_dis_q;
		if (mgmt_wr)
			arm_d = 1'b0; // R2
		if (wr_ext)
		begin
			arm_d      = mgmt_wdata[PQS_EXT_OVR_ARM]; // R1
			scr_test_d = mgmt_wdata[PQS_EXT_SCR_TEST];
			nrzi_d     = mgmt_wdata[PQS_EXT_NRZI];
			inv_code_d = mgmt_wdata[PQS_EXT_INV_CODE];
			scr_dis_d  = mgmt_wdata[PQS_EXT_SCR_DIS];
		end
		if (soft_reset)
		begin
			arm_d      = PQS_RST_OVR_ARM;
			scr_test_d = PQS_RST_SCR_TEST;
			nrzi_d     = PQS_RST_NRZI;
			inv_code_d = PQS_RST_INV_CODE;
			scr_dis_d  = PQS_RST_SCR_DIS;
		end
	end

	// Guarded bits elsewhere may change only on the write right after arming
	assign guard_write_en = arm_q && mgmt_wr && !wr_ext; // R1 R3

	// Status latches; a new event beats the clear of a read in the same cycle
	always_comb
	begin
		ev_d   = ev_q | status_events; // R15 R16 R17 R18
		link_d = link_q & link_valid; // R19
		mon_d  = mon_q;
		if (rd_qp)
		begin
			ev_d   = status_events; // R21
			link_d = link_valid;
		end
		if (!an_enable || an_restart)
			mon_d = PQS_RST_MON; // R23
		else if (an_state > mon_q)
			mon_d = an_state; // R22
		if (soft_reset)
		begin
			ev_d   = PQS_RST_EV;
			link_d = PQS_RST_LINK;
			mon_d  = PQS_RST_MON;
		end
	end

	// Register images; reserved positions are held at zero
	always_comb
	begin
		ext_view = 16'h0000; // R4
		ext_view[PQS_EXT_OVR_ARM]                = arm_q;
		ext_view[PQS_EXT_ADDR_LO +: 5]           = phy_addr_q;
		ext_view[PQS_EXT_SCR_TEST]               = scr_test_q;
		ext_view[PQS_EXT_NRZI]                   = nrzi_q;
		ext_view[PQS_EXT_INV_CODE]               = inv_code_q;
		ext_view[PQS_EXT_SCR_DIS]                = scr_dis_q;
		qp_view  = 16'h0000; // R14
		qp_view[PQS_QP_RATE]                     = speed100;
		qp_view[PQS_QP_DUPLEX]                   = duplex_full;
		qp_view[PQS_QP_MON_LO +: 3]              = mon_q;
		qp_view[10:5]                            = {ev_q[PQS_EV_SIG_LOST], ev_q[PQS_EV_PLL_ERR],
			ev_q[PQS_EV_FALSE_CAR], ev_q[PQS_EV_INV_SYM], ev_q[PQS_EV_HALT], ev_q[PQS_EV_PREM_END]};
		qp_view[PQS_QP_AN_DONE]                  = an_complete;
		qp_view[PQS_QP_NO_SIGNAL]                = !rx_signal_present; // R20
		qp_view[2:1]                             = {ev_q[PQS_EV_JABBER], ev_q[PQS_EV_REM_FAULT]};
		qp_view[PQS_QP_LINK]                     = link_q;
		rdata_d  = rdata_q;
		if (mgmt_rd)
		begin
			if (mgmt_addr == PQS_ADDR_EXT_CTRL)
				rdata_d = ext_view;
			else if (mgmt_addr == PQS_ADDR_QUICK_POLL)
				rdata_d = qp_view;
			else
				rdata_d = 16'h0000;
		end
	end

	// Transmit code choice and serial line coding
	always_comb
	begin
		if (inv_code_q && tx_er)
			tx_code_d = alt_code(tx_nibble); // R10
		else
			tx_code_d = tx_std_code;
		if (speed100 && nrzi_q)
			tx_serial_d = tx_serial_q ^ tx_bit; // R9
		else
			tx_serial_d = tx_bit;
	end

	// Scrambler paths only at 100 Mb/s; disable bypasses both directions
	assign scramble_en    = speed100 && !scr_dis_q; // R12 R13
	assign descramble_en  = speed100 && !scr_dis_q; // R12 R13
	assign desc_lock_loss = scr_test_q; // R8

	// State registers
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			strap_cnt_q <= PQS_STRAP_DLY;
			phy_addr_q  <= PQS_RST_PHY_ADDR;
			arm_q       <= PQS_RST_OVR_ARM;
			scr_test_q  <= PQS_RST_SCR_TEST;
			nrzi_q      <= PQS_RST_NRZI;
			inv_code_q  <= PQS_RST_INV_CODE;
			scr_dis_q   <= PQS_RST_SCR_DIS;
			ev_q        <= PQS_RST_EV;
			link_q      <= PQS_RST_LINK;
			mon_q       <= PQS_RST_MON;
			rdata_q     <= 16'h0000;
			rd_valid_q  <= 1'b0;
			tx_code_q   <= 5'h00;
			tx_serial_q <= 1'b0;
		end
		else
		begin
			strap_cnt_q <= strap_cnt_d;
			phy_addr_q  <= phy_addr_d;
			arm_q       <= arm_d;
			scr_test_q  <= scr_test_d;
			nrzi_q      <= nrzi_d;
			inv_code_q  <= inv_code_d;
			scr_dis_q   <= scr_dis_d;
			ev_q        <= ev_d;
			link_q      <= link_d;
			mon_q       <= mon_d;
			rdata_q     <= rdata_d;
			rd_valid_q  <= mgmt_rd;
			tx_code_q   <= tx_code_d;
			tx_serial_q <= tx_serial_d;
		end
	end

	assign mgmt_rdata    = rdata_q;
	assign mgmt_rd_valid = rd_valid_q;
	assign phy_addr      = phy_addr_q;
	assign tx_code       = tx_code_q;
	assign tx_serial     = tx_serial_q;

	property p_arm_drops;
		@(posedge core_clk) disable iff (reset)
		(mgmt_wr && arm_q && !wr_ext) |=> !arm_q;
	endproperty
	a_arm_drops: assert property (p_arm_drops) else $error("arm bit survived a write"); // R2
	property p_guard_needs_arm;
		@(posedge core_clk) disable iff (reset)
		$rose(arm_q) |-> $past(wr_ext && mgmt_wdata[PQS_EXT_OVR_ARM] && !soft_reset);
	endproperty
	a_guard_needs_arm: assert property (p_guard_needs_arm) else $error("guarded write unarmed"); // R1
	property p_rsvd_zero;
		@(posedge core_clk) disable iff (reset)
		(mgmt_rd && mgmt_addr == PQS_ADDR_EXT_CTRL) |=> (mgmt_rdata[14:11] == 4'h0)
			&& !mgmt_rdata[4] && !mgmt_rdata[1];
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero"); // R4
	property p_addr_kept;
		@(posedge core_clk) disable iff (reset)
		(strap_cnt_q == 2'h0) |=> $stable(phy_addr_q);
	endproperty
	a_addr_kept: assert property (p_addr_kept) else $error("port address changed"); // R7
	property p_lock_loss;
		@(posedge core_clk) disable iff (reset)
		(wr_ext && mgmt_wdata[PQS_EXT_SCR_TEST] && !soft_reset) |=> desc_lock_loss;
	endproperty
	a_lock_loss: assert property (p_lock_loss) else $error("lock loss not forced"); // R8
	property p_nrzi;
		@(posedge core_clk) disable iff (reset)
		(speed100 && nrzi_q) |=> tx_serial_q == ($past(tx_serial_q) ^ $past(tx_bit));
	endproperty
	a_nrzi: assert property (p_nrzi) else $error("NRZI coding wrong"); // R9
	property p_alt_map;
		@(posedge core_clk) disable iff (reset)
		(inv_code_q && tx_er && tx_nibble == 4'h9) |=> tx_code_q == 5'h0d;
	endproperty
	a_alt_map: assert property (p_alt_map) else $error("alternate map wrong"); // R11
	property p_scr_speed;
		@(posedge core_clk) disable iff (reset)
		!speed100 |-> !scramble_en && !descramble_en;
	endproperty
	a_scr_speed: assert property (p_scr_speed) else $error("scrambler on at 10 Mb/s"); // R13
	property p_event_held;
		@(posedge core_clk) disable iff (reset)
		(status_events[PQS_EV_HALT] && !soft_reset) |=> ev_q[PQS_EV_HALT]
			##1 (ev_q[PQS_EV_HALT] || $past(rd_qp || soft_reset));
	endproperty
	a_event_held: assert property (p_event_held) else $error("halt flag dropped early"); // R15
	property p_link_low;
		@(posedge core_clk) disable iff (reset)
		(!link_valid && !rd_qp) ##1 !rd_qp |=> !link_q;
	endproperty
	a_link_low: assert property (p_link_low) else $error("link bit did not latch low"); // R19
	property p_mon_clear;
		@(posedge core_clk) disable iff (reset)
		!an_enable |=> mon_q == 3'h0;
	endproperty
	a_mon_clear: assert property (p_mon_clear) else $error("monitor not cleared"); // R23

endmodule

// >>> src/pqs_pkg.sv
// Register map, field positions, reset values and counts for the extended control and quick poll block
package pqs_pkg;
	// Register addresses on the management port
	localparam logic [4:0]  PQS_ADDR_EXT_CTRL   = 5'h10;
	localparam logic [4:0]  PQS_ADDR_QUICK_POLL = 5'h11;

	// Extended control register fields
	localparam int          PQS_EXT_OVR_ARM     = 15;
	localparam int          PQS_EXT_ADDR_LO     = 6;
	localparam int          PQS_EXT_SCR_TEST    = 5;
	localparam int          PQS_EXT_NRZI        = 3;
	localparam int          PQS_EXT_INV_CODE    = 2;
	localparam int          PQS_EXT_SCR_DIS     = 0;

	// Extended control reset values
	localparam logic        PQS_RST_OVR_ARM     = 1'b0;
	localparam logic        PQS_RST_SCR_TEST    = 1'b0;
	localparam logic        PQS_RST_NRZI        = 1'b1;
	localparam logic        PQS_RST_INV_CODE    = 1'b0;
	localparam logic        PQS_RST_SCR_DIS     = 1'b0;

	// Quick poll register fields
	localparam int          PQS_QP_RATE         = 15;
	localparam int          PQS_QP_DUPLEX       = 14;
	localparam int          PQS_QP_MON_LO       = 11;
	localparam int          PQS_QP_AN_DONE      = 4;
	localparam int          PQS_QP_NO_SIGNAL    = 3;
	localparam int          PQS_QP_LINK         = 0;

	// Latch high event flags, index into the event vector
	localparam int          PQS_EV_COUNT        = 8;
	localparam int          PQS_EV_SIG_LOST     = 0;
	localparam int          PQS_EV_PLL_ERR      = 1;
	localparam int          PQS_EV_FALSE_CAR    = 2;
	localparam int          PQS_EV_INV_SYM      = 3;
	localparam int          PQS_EV_HALT         = 4;
	localparam int          PQS_EV_PREM_END     = 5;
	localparam int          PQS_EV_JABBER       = 6;
	localparam int          PQS_EV_REM_FAULT    = 7;

	// Quick poll reset values
	localparam logic [PQS_EV_COUNT-1:0] PQS_RST_EV = 8'h00;
	localparam logic [2:0]  PQS_RST_MON         = 3'h0;
	localparam logic        PQS_RST_LINK        = 1'b0;

	// Edges after reset release before the address straps are taken
	localparam logic [1:0]  PQS_STRAP_DLY       = 2'h3;
	localparam logic [1:0]  PQS_STRAP_TAKE      = 2'h1;
	localparam logic [4:0]  PQS_RST_PHY_ADDR    = 5'h00;
endpackage

// >>> bench/pqs_sta_model.sv
// Station management model issuing register frames on the parallel strobe port
`timescale 1ns/10ps
module pqs_sta_model
	import pqs_pkg::*;
(
	input  wire logic        core_clk,
	output logic             mgmt_wr,
	output logic             mgmt_rd,
	output logic      [4:0]  mgmt_addr,
	output logic      [15:0] mgmt_wdata
);
	// Writable control bits; reserved and address bits go out at their default unless raw
	localparam logic [15:0] WR_MASK = 16'h802d;

	// Port idles with both strobes low
	initial
	begin
		mgmt_wr    = 1'b0;
		mgmt_rd    = 1'b0;
		mgmt_addr  = 5'h00;
		mgmt_wdata = 16'h0000;
	end

	// One write frame; raw leaves reserved bits as given, only to provoke the device
	task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic raw);
		@(posedge core_clk);
		mgmt_wr    <= 1'b1;
		mgmt_addr  <= a;
		mgmt_wdata <= (raw || a != PQS_ADDR_EXT_CTRL) ? d : (d & WR_MASK);
		@(posedge core_clk);
		mgmt_wr    <= 1'b0;
		mgmt_addr  <= ~a; // Released lines do not keep their last value
		mgmt_wdata <= ~d;
	endtask

	// One read frame; data comes back on the device's valid pulse
	task automatic rd(input logic [4:0] a);
		@(posedge core_clk);
		mgmt_rd   <= 1'b1;
		mgmt_addr <= a;
		@(posedge core_clk);
		mgmt_rd   <= 1'b0;
		mgmt_addr <= ~a;
	endtask
endmodule

// >>> bench/pqs_regs_tb_top.sv
// Self-checking bench for the extended control and quick poll registers
`timescale 1ns/10ps
module pqs_regs_tb_top;
	import pqs_pkg::*;
	logic        core_clk, reset, soft_reset, hw_mode_pin, speed_sel_pin, duplex_sel_pin;
	logic        speed_sel_ctrl, duplex_ctrl, tx_er, tx_bit, link_valid, rx_signal_present;
	logic        an_enable, an_restart, an_complete, mgmt_wr, mgmt_rd, mgmt_rd_valid;
	logic        guard_write_en, tx_serial, scramble_en, descramble_en, desc_lock_loss;
	logic        ctl_nrzi, exp_ser, ser_chk, guard_seen;
	logic [2:0]  an_state;
	logic [3:0]  tx_nibble;
	logic [4:0]  led_addr_pins, mgmt_addr, tx_std_code, tx_code, phy_addr, strap;
	logic [7:0]  status_events;
	logic [15:0] mgmt_wdata, mgmt_rdata, e;
	logic [15:0] exp_q[$];
	int          err_count, tests_run;

	pqs_sta_model sta (.core_clk(core_clk), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata));

	pqs_regs dut (.core_clk(core_clk), .reset(reset), .soft_reset(soft_reset),
		.led_addr_pins(led_addr_pins), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rd_valid(mgmt_rd_valid), .guard_write_en(guard_write_en), .phy_addr(phy_addr),
		.hw_mode_pin(hw_mode_pin), .speed_sel_pin(speed_sel_pin),
		.duplex_sel_pin(duplex_sel_pin), .speed_sel_ctrl(speed_sel_ctrl),
		.duplex_ctrl(duplex_ctrl), .tx_nibble(tx_nibble), .tx_er(tx_er),
		.tx_std_code(tx_std_code), .tx_code(tx_code), .tx_bit(tx_bit), .tx_serial(tx_serial),
		.scramble_en(scramble_en), .descramble_en(descramble_en),
		.desc_lock_loss(desc_lock_loss), .status_events(status_events),
		.link_valid(link_valid), .rx_signal_present(rx_signal_present),
		.an_enable(an_enable), .an_restart(an_restart), .an_state(an_state),
		.an_complete(an_complete));

	// Free-running 125 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Note the expected word, then issue the read
	task automatic rd_exp(input logic [4:0] a, input logic [15:0] x);
		exp_q.push_back(x);
		sta.rd(a);
	endtask

	function automatic logic [4:0] alt_map(input logic [3:0] n);
		logic [4:0] hi [8];
		hi = '{5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f};
		return n[3] ? hi[n[2:0]] : {2'b00, n[2:0]};
	endfunction

	// Quick poll image in software mode
	function automatic logic [15:0] qp(input logic [7:0] ev, input logic [2:0] mon, input logic lk);
		return {speed_sel_ctrl, duplex_ctrl, mon, ev[0], ev[1], ev[2], ev[3], ev[4], ev[5],
			an_complete, ~rx_signal_present, ev[6], ev[7], lk};
	endfunction

	task automatic tx_try(input logic [3:0] n, input logic er, input logic alt);
		logic [4:0] std;
		std = 5'($urandom);
		@(posedge core_clk);
		tx_nibble   <= n;
		tx_er       <= er;
		tx_std_code <= std;
		repeat (2) @(posedge core_clk);
		check("tx code", {11'h0, tx_code}, {11'h0, alt ? alt_map(n) : std});
	endtask

	// Read answers are compared in order against the noted words
	always @(posedge core_clk)
		if (mgmt_rd_valid === 1'b1)
			check("read data", mgmt_rdata, exp_q.pop_front());

	// Serial line reference, NRZI only at 100 Mb/s with the encoding bit set
	always @(posedge core_clk)
	begin
		if (ser_chk)
			check("serial", {15'h0, tx_serial}, {15'h0, exp_ser});
		exp_ser <= (speed_sel_ctrl & ctl_nrzi) ? exp_ser ^ tx_bit : tx_bit;
	end

	always @(posedge core_clk)
		if (mgmt_wr === 1'b1)
			guard_seen <= guard_write_en;

	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		close_out();
	end

	initial
	begin
		{soft_reset, hw_mode_pin, speed_sel_pin, duplex_sel_pin, tx_er, tx_bit} = 6'h00;
		{an_enable, an_restart, an_complete, link_valid, rx_signal_present} = 5'h00;
		{ser_chk, exp_ser, guard_seen, duplex_ctrl} = 4'h0;
		{tx_nibble, tx_std_code, an_state, status_events} = 20'h00000;
		reset = 1'b1;
		speed_sel_ctrl = 1'b1;
		ctl_nrzi = 1'b1;
		err_count = 0;
		tests_run = 0;
		void'($urandom(32'h5ccb8502));
		strap = 5'($urandom) | 5'h01;
		led_addr_pins = strap;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		ser_chk <= 1'b1;
		check("port address", {11'h0, phy_addr}, {11'h0, strap});
		rd_exp(PQS_ADDR_EXT_CTRL, {5'h00, strap, 6'h08});
		rd_exp(5'h05, 16'h0000);
		sta.wr(PQS_ADDR_EXT_CTRL, 16'hffff, 1'b1);
		rd_exp(PQS_ADDR_EXT_CTRL, {1'b1, 4'h0, strap, 6'h2d});
		check("lock loss", {15'h0, desc_lock_loss}, 16'h0001);
		sta.wr(PQS_ADDR_QUICK_POLL, 16'h1234, 1'b0);
		rd_exp(PQS_ADDR_EXT_CTRL, {1'b0, 4'h0, strap, 6'h2d});
		check("guard armed", {15'h0, guard_seen}, 16'h0001);
		sta.wr(PQS_ADDR_QUICK_POLL, 16'h5678, 1'b0);
		rd_exp(PQS_ADDR_EXT_CTRL, {1'b0, 4'h0, strap, 6'h2d});
		check("guard unarmed", {15'h0, guard_seen}, 16'h0000);
		$display("test arming done");
		led_addr_pins <= ~strap;
		soft_reset <= 1'b1;
		@(posedge core_clk);
		soft_reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		check("port address", {11'h0, phy_addr}, {11'h0, strap});
		rd_exp(PQS_ADDR_EXT_CTRL, {5'h00, strap, 6'h08});
		$display("test soft reset done");
		for (int c = 0; c < 4; c++)
		begin
			speed_sel_ctrl <= c[1];
			sta.wr(PQS_ADDR_EXT_CTRL, {12'h0, c[0], 2'b00, c[0] ^ c[1]}, 1'b0);
			ctl_nrzi <= c[0];
			@(posedge core_clk);
			check("scramble", {15'h0, scramble_en}, {15'h0, c[1] & ~(c[0] ^ c[1])});
			check("descramble", {15'h0, descramble_en}, {15'h0, c[1] & ~(c[0] ^ c[1])});
			repeat (12)
			begin
				@(posedge core_clk);
				tx_bit <= 1'($urandom);
			end
		end
		$display("test line coding done");
		sta.wr(PQS_ADDR_EXT_CTRL, 16'h000c, 1'b0);
		for (int k = 0; k < 32; k++)
			tx_try(4'(k), k < 16, k < 16);
		sta.wr(PQS_ADDR_EXT_CTRL, 16'h0008, 1'b0);
		tx_try(4'hb, 1'b1, 1'b0);
		$display("test code map done");
		link_valid <= 1'b1;
		an_enable <= 1'b1;
		an_complete <= 1'($urandom);
		rx_signal_present <= 1'($urandom);
		@(posedge core_clk);
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h0, 1'b0));
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h0, 1'b1));
		for (int i = 0; i < 8; i++)
		begin
			@(posedge core_clk);
			status_events <= 8'(1 << i);
			@(posedge core_clk);
			status_events <= 8'h00;
			rd_exp(PQS_ADDR_QUICK_POLL, qp(8'(1 << i), 3'h0, 1'b1));
			rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h0, 1'b1));
		end
		link_valid <= 1'b0;
		@(posedge core_clk);
		link_valid <= 1'b1;
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h0, 1'b0));
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h0, 1'b1));
		an_state <= 3'h3;
		repeat (2) @(posedge core_clk);
		an_state <= 3'h1;
		repeat (2) @(posedge core_clk);
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h3, 1'b1));
		an_state <= 3'h5;
		repeat (2) @(posedge core_clk);
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h5, 1'b1));
		an_state <= 3'h0;
		an_restart <= 1'b1;
		@(posedge core_clk);
		an_restart <= 1'b0;
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h0, 1'b1));
		an_state <= 3'h6;
		repeat (2) @(posedge core_clk);
		an_enable <= 1'b0;
		repeat (2) @(posedge core_clk);
		rd_exp(PQS_ADDR_QUICK_POLL, qp(8'h00, 3'h0, 1'b1));
		$display("test quick poll done");
		ser_chk <= 1'b0;
		hw_mode_pin <= 1'b1;
		speed_sel_pin <= ~speed_sel_ctrl;
		duplex_sel_pin <= ~duplex_ctrl;
		repeat (4) @(posedge core_clk);
		e = qp(8'h00, 3'h0, 1'b1);
		e[15:14] = ~e[15:14];
		rd_exp(PQS_ADDR_QUICK_POLL, e);
		repeat (3) @(posedge core_clk);
		$display("test hardware mode done");
		// Second hardware reset must take the pins as they stand now
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		check("port address", {11'h0, phy_addr}, {11'h0, ~strap});
		rd_exp(PQS_ADDR_EXT_CTRL, {5'h00, ~strap, 6'h08});
		repeat (3) @(posedge core_clk);
		$display("test hardware reset done");
		close_out();
	end
endmodule
